// File: lbc_pkg.sv
// Package of constants and carrier types for the local bus configuration block
package lbc_pkg;

	// ****************************************************************
	// Register offsets
	// ****************************************************************
	localparam logic [7:0] OFS_CONFIG   = 8'h40;
	localparam logic [7:0] OFS_CTRL_PTR = 8'h44;
	localparam logic [7:0] OFS_START    = 8'h4C;
	localparam logic [7:0] OFS_TXQ_BASE = 8'h50;
	localparam logic [7:0] OFS_TXQ_LEN  = 8'h54;
	localparam logic [7:0] OFS_RXQ_BASE = 8'h58;
	localparam logic [7:0] OFS_RXQ_LEN  = 8'h5C;
	localparam logic [7:0] OFS_PTR_SET0 = 8'h60;
	localparam logic [7:0] OFS_PTR_SET1 = 8'h64;
	localparam logic [7:0] OFS_EVT_STAT = 8'hF0;  // Block state readback
	localparam logic [7:0] OFS_GP_DIR   = 8'hF4;  // Phase-one pin directions

	// ****************************************************************
	// Reset values and masks
	// ****************************************************************
	localparam logic [31:0] RST_CONFIG  = 32'h0060_0000;
	localparam logic [31:0] RST_START   = 32'h0000_0003;
	localparam logic [31:0] MASK_CONFIG = 32'hFF7C_1FFF;
	localparam logic [31:0] MASK_ALIGN  = 32'hFFFF_FFFC;
	localparam logic [31:0] MASK_LEN    = 32'h0000_00FF;

	// ****************************************************************
	// Config field positions
	// ****************************************************************
	localparam int B_WAIT_LO = 0;
	localparam int B_ROLE    = 4;
	localparam int B_READY   = 5;
	localparam int B_SEP_IRQ = 10;
	localparam int B_POL2    = 11;
	localparam int B_POL1    = 12;
	localparam int B_VAL_LO  = 18;
	localparam int B_SM_RST  = 21;
	localparam int B_BC_RST  = 22;
	localparam int B_COMB    = 24;
	localparam int B_DIR     = 25;
	localparam int B_SHARED  = 26;
	localparam int B_MODE_B  = 27;
	localparam int B_MODE_A  = 28;
	localparam int B_DISR_B  = 29;
	localparam int B_DISR_A  = 30;
	localparam int B_PASS    = 31;

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam logic [3:0] MAX_WAITS = 4'hF;
	localparam logic [2:0] VAL_NONE  = 3'h0;
	localparam logic [2:0] VAL_8     = 3'h5;
	localparam logic [2:0] VAL_16    = 3'h6;
	localparam logic [2:0] VAL_32    = 3'h7;
	localparam logic [5:0] CNT_8     = 6'h08;
	localparam logic [5:0] CNT_16    = 6'h10;
	localparam logic [5:0] CNT_32    = 6'h20;
	localparam logic [3:0] QLEN_SHIFT = 4'h4;  // 16 words per length step

	typedef enum logic [1:0] {BC_IDLE, BC_WAIT, BC_READY} lbc_bus_e;

	// Interrupt queue event carrier
	typedef struct packed {
		logic        rx;      // Queue select
		logic        chan_b;  // Channel of origin
		logic [7:0]  code;    // Status word payload
	} lbc_event_s;

endpackage : lbc_pkg

// File: lbc_top.sv
// Local bus configuration registers and the control logic they steer
`timescale 1ns/1ps
`default_nettype none
module lbc_top #(
	parameter int ADDR_W = 8
) (
	input  wire logic              core_clk,
	input  wire logic              sys_rst,
	input  wire logic [ADDR_W-1:0] reg_addr,
	input  wire logic [31:0]       reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic [31:0]            reg_rdata_ff,
	input  wire logic              bus_cycle_req,
	input  wire logic              peripheral_ready_input,
	output logic                   bus_cycle_done_ff,
	input  wire logic              hold_acknowledge_pin_in,
	output logic                   hold_acknowledge_pin_out_ff,
	output logic                   hold_acknowledge_pin_oe_n_ff,
	input  wire logic              hold_request_pin,
	output logic                   arb_granted_ff,
	input  wire logic              dma_request_a,
	input  wire logic              dma_request_b,
	input  wire logic [3:0]        dma_ack_int,
	output logic                   dma_ack_tx_a_ff,
	output logic                   dma_ack_rx_a_ff,
	output logic                   dma_ack_tx_b_ff,
	output logic                   dma_ack_rx_b_ff,
	output logic                   dma_ack_combined_a_ff,
	output logic                   dma_ack_combined_b_ff,
	output logic                   req_a_valid_ff,
	output logic                   req_a_tx_ff,
	output logic                   req_b_valid_ff,
	output logic                   bus_clock_phase_one_out_ff,
	output logic                   extra_clock_phase_one_out_ff,
	input  wire logic              local_bus_clock_out,
	input  wire logic              peripheral_irq_in_1,
	input  wire logic              peripheral_irq_in_2,
	input  wire logic [1:0]        irq_is_upper_status,
	output logic                   irq_a_ff,
	output logic                   irq_b_ff,
	output logic [1:0]             irq_to_queue_ff,
	output logic [1:0]             chan_dma_mode_ff,
	input  wire logic              evt_valid,
	input  wire lbc_pkg::lbc_event_s evt_in,
	input  wire logic              evt_masked,
	output logic                   q_wr_ff,
	output logic [31:0]            q_addr_ff,
	output logic [31:0]            q_data_ff,
	output logic                   host_irq_ff,
	output logic [1:0]             tx_fetch_ff,
	input  wire logic [1:0]        tx_hold,
	output logic [31:0]            ctrl_block_addr_ff,
	output logic [31:0]            periph_ptrs_a_ff,
	output logic [31:0]            periph_ptrs_a1_ff,
	output logic                   sm_in_reset_ff,
	output logic                   bc_in_reset_ff
);

	// ****************************************************************
	// Register storage
	// ****************************************************************
	logic [31:0] cfg_ff, start_ff, txb_ff, txl_ff, rxb_ff, rxl_ff;
	logic [31:0] ptr0_ff, ptr1_ff;
	logic [1:0]  gp_direction_reg_ff;
	logic [11:0] txwp_ff, rxwp_ff;   // Word index into each queue
	lbc_pkg::lbc_bus_e bc_st_ff;
	logic [3:0]  wait_cnt_ff;
	logic [5:0]  val_cnt_a_ff, val_cnt_b_ff;
	logic        lclk_d_ff;

	wire logic sm_run = cfg_ff[lbc_pkg::B_SM_RST];
	wire logic bc_run = cfg_ff[lbc_pkg::B_BC_RST];
	wire logic wr_hit = reg_wr;

	// Host writes; reserved bits and alignment bits forced to zero
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			cfg_ff   <= lbc_pkg::RST_CONFIG;
			txb_ff   <= 32'h0000_0000;
			txl_ff   <= 32'h0000_0000;
			rxb_ff   <= 32'h0000_0000;
			rxl_ff   <= 32'h0000_0000;
			ptr0_ff  <= 32'h0000_0000;
			ptr1_ff  <= 32'h0000_0000;
			ctrl_block_addr_ff <= 32'h0000_0000;
			gp_direction_reg_ff <= 2'h0;
		end else if (wr_hit) begin
			case (reg_addr[7:0])
				lbc_pkg::OFS_CONFIG:   cfg_ff <= reg_wdata & lbc_pkg::MASK_CONFIG;
				lbc_pkg::OFS_CTRL_PTR: ctrl_block_addr_ff <= reg_wdata & lbc_pkg::MASK_ALIGN;
				lbc_pkg::OFS_TXQ_BASE: txb_ff <= reg_wdata & lbc_pkg::MASK_ALIGN;
				lbc_pkg::OFS_TXQ_LEN:  txl_ff <= reg_wdata & lbc_pkg::MASK_LEN;
				lbc_pkg::OFS_RXQ_BASE: rxb_ff <= reg_wdata & lbc_pkg::MASK_ALIGN;
				lbc_pkg::OFS_RXQ_LEN:  rxl_ff <= reg_wdata & lbc_pkg::MASK_LEN;
				lbc_pkg::OFS_PTR_SET0: ptr0_ff <= reg_wdata;
				lbc_pkg::OFS_PTR_SET1: ptr1_ff <= reg_wdata;
				lbc_pkg::OFS_GP_DIR:   gp_direction_reg_ff <= reg_wdata[1:0];
				default: ;
			endcase
		end
	end

	// Pointer registers feed the peripheral addressing directly
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			periph_ptrs_a_ff  <= 32'h0000_0000;
			periph_ptrs_a1_ff <= 32'h0000_0000;
		end else begin
			periph_ptrs_a_ff  <= ptr0_ff;
			periph_ptrs_a1_ff <= ptr1_ff;
		end
	end

	// ****************************************************************
	// Start bits: writing zero launches a fetch, bit returns to one
	// ****************************************************************
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			start_ff    <= lbc_pkg::RST_START;
			tx_fetch_ff <= 2'h0;
		end else begin
			tx_fetch_ff <= 2'h0;
			start_ff    <= lbc_pkg::RST_START;
			if (wr_hit && reg_addr[7:0] == lbc_pkg::OFS_START && sm_run) begin
				for (int i = 0; i < 2; i++) begin
					if (!reg_wdata[i] && !tx_hold[i])
						tx_fetch_ff[i] <= 1'b1;
				end
			end
		end
	end

	// ****************************************************************
	// Reads: one cycle later, unmapped reads zero
	// ****************************************************************
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			reg_rdata_ff <= 32'h0000_0000;
		end else if (reg_rd) begin
			case (reg_addr[7:0])
				lbc_pkg::OFS_CONFIG:   reg_rdata_ff <= cfg_ff;
				lbc_pkg::OFS_CTRL_PTR: reg_rdata_ff <= ctrl_block_addr_ff;
				lbc_pkg::OFS_START:    reg_rdata_ff <= start_ff;
				lbc_pkg::OFS_TXQ_BASE: reg_rdata_ff <= txb_ff;
				lbc_pkg::OFS_TXQ_LEN:  reg_rdata_ff <= txl_ff;
				lbc_pkg::OFS_RXQ_BASE: reg_rdata_ff <= rxb_ff;
				lbc_pkg::OFS_RXQ_LEN:  reg_rdata_ff <= rxl_ff;
				lbc_pkg::OFS_PTR_SET0: reg_rdata_ff <= ptr0_ff;
				lbc_pkg::OFS_PTR_SET1: reg_rdata_ff <= ptr1_ff;
				lbc_pkg::OFS_GP_DIR:   reg_rdata_ff <= {30'h0, gp_direction_reg_ff};
				lbc_pkg::OFS_EVT_STAT: reg_rdata_ff <= {4'h0, rxwp_ff,
					4'h0, txwp_ff};
				default:               reg_rdata_ff <= 32'h0000_0000;
			endcase
		end else begin
			reg_rdata_ff <= 32'h0000_0000;
		end
	end

	// ****************************************************************
	// External bus cycle timing
	// ****************************************************************
	wire logic [3:0] nxt_waits = lbc_pkg::MAX_WAITS - cfg_ff[3:0];

	// Cycle engine held idle while the controller reset bit is zero
	always_ff @(posedge core_clk) begin
		if (sys_rst || !bc_run) begin
			bc_st_ff          <= lbc_pkg::BC_IDLE;
			wait_cnt_ff       <= 4'h0;
			bus_cycle_done_ff <= 1'b0;
		end else begin
			bus_cycle_done_ff <= 1'b0;
			case (bc_st_ff)
				lbc_pkg::BC_IDLE: begin
					if (bus_cycle_req) begin
						wait_cnt_ff <= nxt_waits;
						bc_st_ff    <= lbc_pkg::BC_WAIT;
					end
				end
				lbc_pkg::BC_WAIT: begin
					if (wait_cnt_ff != 4'h0) begin
						wait_cnt_ff <= wait_cnt_ff - 4'h1;
					end else if (cfg_ff[lbc_pkg::B_READY]) begin
						bc_st_ff <= lbc_pkg::BC_READY;
					end else begin
						bus_cycle_done_ff <= 1'b1;
						bc_st_ff          <= lbc_pkg::BC_IDLE;
					end
				end
				lbc_pkg::BC_READY: begin
					if (peripheral_ready_input) begin
						bus_cycle_done_ff <= 1'b1;
						bc_st_ff          <= lbc_pkg::BC_IDLE;
					end
				end
				default: bc_st_ff <= lbc_pkg::BC_IDLE;
			endcase
		end
	end

	// Arbitration role decides direction of hold acknowledge
	always_ff @(posedge core_clk) begin
		if (sys_rst || !bc_run) begin
			hold_acknowledge_pin_out_ff  <= 1'b0;
			hold_acknowledge_pin_oe_n_ff <= 1'b1;
			arb_granted_ff               <= 1'b0;
		end else if (cfg_ff[lbc_pkg::B_ROLE]) begin
			hold_acknowledge_pin_oe_n_ff <= 1'b0;
			hold_acknowledge_pin_out_ff  <= hold_request_pin;
			arb_granted_ff               <= !hold_request_pin;
		end else begin
			hold_acknowledge_pin_oe_n_ff <= 1'b1;
			hold_acknowledge_pin_out_ff  <= 1'b0;
			arb_granted_ff               <= hold_acknowledge_pin_in;
		end
	end

	// ****************************************************************
	// DMA request validation and acknowledges
	// ****************************************************************
	logic [5:0] val_len;
	always_comb begin
		case (cfg_ff[20:18])
			lbc_pkg::VAL_8:  val_len = lbc_pkg::CNT_8;
			lbc_pkg::VAL_16: val_len = lbc_pkg::CNT_16;
			lbc_pkg::VAL_32: val_len = lbc_pkg::CNT_32;
			default:         val_len = 6'h00;  // No delay; reserved acts alike
		endcase
	end

	// Falling edge of the bus clock counts the hold-off periods
	wire logic lclk_fall = lclk_d_ff && !local_bus_clock_out;

	always_ff @(posedge core_clk) begin
		if (sys_rst || !sm_run) begin
			lclk_d_ff      <= 1'b0;
			val_cnt_a_ff   <= 6'h00;
			val_cnt_b_ff   <= 6'h00;
			req_a_valid_ff <= 1'b0;
			req_b_valid_ff <= 1'b0;
			req_a_tx_ff    <= 1'b0;
		end else begin
			lclk_d_ff <= local_bus_clock_out;
			// Request stays valid until the hold-off period has run out
			if (dma_request_a) begin
				val_cnt_a_ff   <= val_len;
				req_a_valid_ff <= 1'b1;
			end else if (val_cnt_a_ff == 6'h00) begin
				req_a_valid_ff <= 1'b0;
			end else if (lclk_fall) begin
				val_cnt_a_ff <= val_cnt_a_ff - 6'h01;
			end
			if (dma_request_b) begin
				val_cnt_b_ff   <= val_len;
				req_b_valid_ff <= 1'b1;
			end else if (val_cnt_b_ff == 6'h00) begin
				req_b_valid_ff <= 1'b0;
			end else if (lclk_fall) begin
				val_cnt_b_ff <= val_cnt_b_ff - 6'h01;
			end
			// Shared pin: direction bit names the request's direction
			req_a_tx_ff <= cfg_ff[lbc_pkg::B_SHARED] ?
				cfg_ff[lbc_pkg::B_DIR] : 1'b1;
		end
	end

	// Acknowledge routing; dma_ack_int is {rx_b, tx_b, rx_a, tx_a}
	always_ff @(posedge core_clk) begin
		if (sys_rst || !sm_run) begin
			dma_ack_tx_a_ff       <= 1'b0;
			dma_ack_rx_a_ff       <= 1'b0;
			dma_ack_tx_b_ff       <= 1'b0;
			dma_ack_rx_b_ff       <= 1'b0;
			dma_ack_combined_a_ff <= 1'b0;
			dma_ack_combined_b_ff <= 1'b0;
		end else begin
			if (cfg_ff[lbc_pkg::B_COMB] || cfg_ff[lbc_pkg::B_SHARED])
				dma_ack_combined_a_ff <= |dma_ack_int[1:0];
			else
				dma_ack_combined_a_ff <= 1'b0;
			dma_ack_combined_b_ff <= cfg_ff[lbc_pkg::B_COMB] &&
				(|dma_ack_int[3:2]);
			dma_ack_tx_a_ff <= !cfg_ff[lbc_pkg::B_COMB] &&
				!cfg_ff[lbc_pkg::B_SHARED] && dma_ack_int[0];
			dma_ack_rx_a_ff <= !cfg_ff[lbc_pkg::B_COMB] &&
				!cfg_ff[lbc_pkg::B_SHARED] && dma_ack_int[1];
			dma_ack_tx_b_ff <= !cfg_ff[lbc_pkg::B_COMB] && dma_ack_int[2];
			dma_ack_rx_b_ff <= !cfg_ff[lbc_pkg::B_COMB] && dma_ack_int[3];
		end
	end

	// Phase-one clocks appear on freed pins only when set as outputs
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			bus_clock_phase_one_out_ff   <= 1'b0;
			extra_clock_phase_one_out_ff <= 1'b0;
		end else begin
			bus_clock_phase_one_out_ff <= cfg_ff[lbc_pkg::B_COMB] &&
				gp_direction_reg_ff[0] && local_bus_clock_out;
			extra_clock_phase_one_out_ff <= cfg_ff[lbc_pkg::B_COMB] &&
				gp_direction_reg_ff[1] && local_bus_clock_out;
		end
	end

	// ****************************************************************
	// Peripheral interrupts
	// ****************************************************************
	wire logic irq1 = peripheral_irq_in_1 ^ cfg_ff[lbc_pkg::B_POL1];
	wire logic irq2 = (peripheral_irq_in_2 ^ cfg_ff[lbc_pkg::B_POL2]) &&
		cfg_ff[lbc_pkg::B_SEP_IRQ];

	always_ff @(posedge core_clk) begin
		if (sys_rst || !sm_run) begin
			irq_a_ff         <= 1'b0;
			irq_b_ff         <= 1'b0;
			irq_to_queue_ff  <= 2'h0;
			chan_dma_mode_ff <= 2'h0;
		end else begin
			irq_a_ff <= irq1;
			irq_b_ff <= cfg_ff[lbc_pkg::B_SEP_IRQ] ? irq2 : irq1;
			irq_to_queue_ff[0] <= cfg_ff[lbc_pkg::B_DISR_A] ||
				(cfg_ff[lbc_pkg::B_PASS] && irq_is_upper_status[0]);
			irq_to_queue_ff[1] <= cfg_ff[lbc_pkg::B_DISR_B] ||
				(cfg_ff[lbc_pkg::B_PASS] && irq_is_upper_status[1]);
			chan_dma_mode_ff <= {cfg_ff[lbc_pkg::B_MODE_B],
				cfg_ff[lbc_pkg::B_MODE_A]};
		end
	end

	// ****************************************************************
	// Interrupt queue writer
	// ****************************************************************
	wire logic [11:0] tx_last = {txl_ff[7:0], 4'hF};
	wire logic [11:0] rx_last = {rxl_ff[7:0], 4'hF};

	always_ff @(posedge core_clk) begin
		if (sys_rst || !sm_run) begin
			txwp_ff     <= 12'h000;
			rxwp_ff     <= 12'h000;
			q_wr_ff     <= 1'b0;
			q_addr_ff   <= 32'h0000_0000;
			q_data_ff   <= 32'h0000_0000;
			host_irq_ff <= 1'b0;
		end else begin
			q_wr_ff     <= evt_valid;
			host_irq_ff <= evt_valid && !evt_masked;
			if (evt_valid) begin
				q_data_ff <= {22'h0, evt_in.rx, evt_in.chan_b, evt_in.code};
				if (evt_in.rx) begin
					q_addr_ff <= rxb_ff + {18'h0, rxwp_ff, 2'h0};
					rxwp_ff <= (rxwp_ff == rx_last) ? 12'h000 :
						rxwp_ff + 12'h001;
				end else begin
					q_addr_ff <= txb_ff + {18'h0, txwp_ff, 2'h0};
					txwp_ff <= (txwp_ff == tx_last) ? 12'h000 :
						txwp_ff + 12'h001;
				end
			end
		end
	end

	// Reset status of the two sub-blocks as software sees it
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			sm_in_reset_ff <= 1'b0;
			bc_in_reset_ff <= 1'b0;
		end else begin
			sm_in_reset_ff <= !sm_run;
			bc_in_reset_ff <= !bc_run;
		end
	end

endmodule : lbc_top
`default_nettype wire

// File: lbc_periph_model.sv
// Behavioural peripheral on the far side of the local bus
`timescale 1ns/1ps
`default_nettype none
module lbc_periph_model (
	input  wire logic       core_clk,
	input  wire logic       sys_rst,
	input  wire logic       bus_cycle_req,
	input  wire logic       bus_cycle_done_ff,
	input  wire logic [3:0] ready_lag,
	input  wire logic [1:0] irq_on,
	input  wire logic       irq_low,
	output logic            peripheral_ready_input,
	output logic            peripheral_irq_in_1,
	output logic            peripheral_irq_in_2,
	output logic            local_bus_clock_out
);
	logic       busy_ff;
	logic [3:0] cnt_ff;
	// Ready comes a chosen lag after the cycle starts; a slow
	// peripheral stretches the cycle past its programmed wait states when ready is enabled
	always_ff @(posedge core_clk) begin
		if (sys_rst || bus_cycle_done_ff) begin
			busy_ff <= 1'b0;
		end else if (bus_cycle_req) begin
			busy_ff <= 1'b1;
			cnt_ff  <= ready_lag;
		end else if (cnt_ff != 4'h0) begin
			cnt_ff <= cnt_ff - 4'h1;
		end
	end
	assign peripheral_ready_input = busy_ff && cnt_ff == 4'h0;
	// Interrupt lines in the level the chosen decoding expects
	assign peripheral_irq_in_1 = irq_on[0] ^ irq_low;
	assign peripheral_irq_in_2 = irq_on[1] ^ irq_low;
	// Bus clock derived from the core clock, free running
	always_ff @(posedge core_clk) begin
		local_bus_clock_out <= sys_rst ? 1'b0 : !local_bus_clock_out;
	end
endmodule : lbc_periph_model
`default_nettype wire

// File: lbc_top_monitor.sv
// Port checker for the local bus configuration block
`timescale 1ns/1ps
`default_nettype none
module lbc_top_monitor #(
	parameter int ADDR_W = 8
) (
	input wire logic              core_clk,
	input wire logic              sys_rst,
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [31:0]       reg_wdata,
	input wire logic              reg_wr,
	input wire logic              reg_rd,
	input wire logic [31:0]       reg_rdata_ff,
	input wire logic              evt_valid,
	input wire logic              evt_masked,
	input wire logic              q_wr_ff,
	input wire logic [31:0]       q_addr_ff,
	input wire logic              host_irq_ff,
	input wire logic [1:0]        tx_fetch_ff,
	input wire logic [1:0]        tx_hold
);
	// ********
	// Properties
	// ********
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	chk_read_idle: assert property (!$past(reg_rd) |-> reg_rdata_ff == 32'h0)
		else $error("read data outside its cycle");
	chk_start_reads: assert property (reg_rd && reg_addr == 8'h4C
		|=> reg_rdata_ff == lbc_pkg::RST_START)
		else $error("start register read wrong");
	chk_len_upper: assert property (reg_rd && (reg_addr == 8'h54 ||
		reg_addr == 8'h5C) |=> reg_rdata_ff[31:8] == 24'h0)
		else $error("queue length upper bits set");
	chk_base_align: assert property (reg_rd && (reg_addr == 8'h50 ||
		reg_addr == 8'h58) |=> reg_rdata_ff[1:0] == 2'h0)
		else $error("queue base not aligned");
	chk_ptr_align: assert property (reg_rd && reg_addr == 8'h44
		|=> reg_rdata_ff[1:0] == 2'h0)
		else $error("control block pointer not aligned");
	chk_evt_write: assert property (evt_valid
		|=> q_wr_ff && q_addr_ff[1:0] == 2'h0)
		else $error("event not written to queue");
	chk_write_cause: assert property (q_wr_ff |-> $past(evt_valid))
		else $error("queue write without event");
	chk_irq_mask: assert property (evt_valid
		|=> host_irq_ff == !$past(evt_masked))
		else $error("host signal ignores mask");
	// Hazard: a channel 0 fetch must never start while channel 0 is held
	chk_fetch_cause: assert property (tx_fetch_ff[0]
		|-> $past(reg_wr && reg_addr == 8'h4C && !reg_wdata[0] &&
		!tx_hold[0]))
		else $error("fetch without start write");
endmodule : lbc_top_monitor
bind lbc_top lbc_top_monitor #(.ADDR_W(ADDR_W)) u_mon (.*);
`default_nettype wire

// File: tb_local_bus_peripheral_config.sv
// Self-checking bench for the local bus configuration block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin \
	failures++; $display("[FAIL] %s exp %0h got %0h", n, e, s); end end
module tb_local_bus_peripheral_config;
	localparam logic [31:0] RST = lbc_pkg::RST_CONFIG;
	localparam logic [7:0]  OFS [10] = '{8'h40, 8'h44, 8'h4C, 8'h50, 8'h54,
		8'h58, 8'h5C, 8'h60, 8'h64, 8'h48};
	localparam logic [31:0] WB [10] = '{32'h0, 32'hFFFF_FFFC, 32'h3,
		32'hFFFF_FFFC, 32'hFF, 32'hFFFF_FFFC, 32'hFF, 32'hFFFF_FFFF,
		32'hFFFF_FFFF, 32'h0};
	logic core_clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
	logic bus_cycle_req = 1'b0, evt_valid = 1'b0, evt_masked = 1'b0;
	logic hold_acknowledge_pin_in = 1'b0, hold_request_pin = 1'b0;
	logic dma_request_a = 1'b0, dma_request_b = 1'b0, irq_low = 1'b0;
	logic [7:0]  reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0, reg_rdata_ff, q_addr_ff, d, q_data_ff;
	logic [31:0] ctrl_block_addr_ff, periph_ptrs_a_ff, periph_ptrs_a1_ff;
	logic [1:0]  irq_is_upper_status = 2'h0, tx_hold = 2'h0, irq_on = 2'h0;
	logic [3:0]  dma_ack_int = 4'h0, ready_lag = 4'h0;
	logic [1:0]  chan_dma_mode_ff, tx_fetch_ff, irq_to_queue_ff;
	logic bus_cycle_done_ff, hold_acknowledge_pin_oe_n_ff, dma_ack_rx_a_ff;
	logic dma_ack_combined_a_ff, dma_ack_combined_b_ff, irq_a_ff, irq_b_ff;
	logic q_wr_ff, host_irq_ff, sm_in_reset_ff, bc_in_reset_ff;
	logic peripheral_ready_input, peripheral_irq_in_1, peripheral_irq_in_2;
	logic local_bus_clock_out;
	logic hold_acknowledge_pin_out_ff, arb_granted_ff, req_a_valid_ff;
	logic req_a_tx_ff, bus_clock_phase_one_out_ff;
	logic extra_clock_phase_one_out_ff;
	lbc_pkg::lbc_event_s evt_in = '{rx: 1'b0, chan_b: 1'b0, code: 8'hA5};
	int failures = 0, comparisons = 0, n0, n1, n2;
	lbc_top u_dut (.*, .dma_ack_tx_a_ff(), .dma_ack_tx_b_ff(),
		.dma_ack_rx_b_ff(), .req_b_valid_ff());
	lbc_periph_model u_model (.*);
	// ********
	// Bus tasks
	// ********
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge core_clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= v;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a);
		@(posedge core_clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata_ff;
	endtask : rd
	task automatic settle;
		repeat (2) @(posedge core_clk);
		#1;
	endtask : settle
	// Settings change framed by both block resets, as software must
	task automatic cfg(input logic [31:0] v);
		wr(8'h40, v & 32'hFF9F_FFFF);
		wr(8'h40, v | 32'h0060_0000);
		settle();
	endtask : cfg
	// One bus cycle, length counted up to its done pulse
	task automatic cyc(output int n);
		@(posedge core_clk);
		bus_cycle_req <= 1'b1;
		@(posedge core_clk);
		bus_cycle_req <= 1'b0;
		for (n = 0; n < 300; n++) begin
			@(posedge core_clk);
			#1;
			if (bus_cycle_done_ff === 1'b1) break;
		end
	endtask : cyc
	task automatic ev(input logic m, input logic [31:0] a);
		@(posedge core_clk);
		evt_valid  <= 1'b1;
		evt_masked <= m;
		@(posedge core_clk);
		evt_valid <= 1'b0;
		#1;
		`CHK("q_wr", 1'b1, q_wr_ff)
		`CHK("q_addr", a, q_addr_ff)
		`CHK("host_irq", !m, host_irq_ff)
		`CHK("q_data", 32'h0000_00A5, q_data_ff)
	endtask : ev
	task automatic report_and_stop;
		if (failures == 0 && comparisons > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : report_and_stop
	// ********
	// Clock, watchdog and tests
	// ********
	initial begin
		forever #5 core_clk = ~core_clk;
	end
	// Generous limit: the whole sequence needs a few hundred cycles
	initial begin
		#200000;
		failures++;
		report_and_stop();
	end
	initial begin
		repeat (4) @(posedge core_clk);
		sys_rst <= 1'b0;
		for (int i = 0; i < 10; i++) begin
			rd(OFS[i]);
			`CHK("reset value", i == 0 ? RST : (i == 2 ? 32'h3 : 32'h0), d)
		end
		// Sixteen-entry queue, so entry sixteen lands on the base again
		wr(8'h50, 32'h0000_1000);
		wr(8'h54, 32'h0);
		for (int i = 0; i < 17; i++) begin
			ev(i == 3, 32'h1000 + 32'(4 * (i % 16)));
		end
		for (int i = 1; i < 10; i++) begin
			wr(OFS[i], 32'hFFFF_FFFF);
			rd(OFS[i]);
			`CHK("readback", WB[i], d)
		end
		`CHK("ptr out", 32'hFFFF_FFFF, periph_ptrs_a_ff & periph_ptrs_a1_ff)
		`CHK("cb addr", 32'hFFFF_FFFC, ctrl_block_addr_ff)
		cfg(32'hFFFF_FFFF);
		rd(8'h40);
		`CHK("config", lbc_pkg::MASK_CONFIG, d)
		`CHK("hold ack driven", 1'b0, hold_acknowledge_pin_oe_n_ff)
		hold_request_pin <= 1'b1;
		settle();
		`CHK("hold ack out", 1'b1, hold_acknowledge_pin_out_ff)
		cfg(RST);
		`CHK("hold ack input", 1'b1, hold_acknowledge_pin_oe_n_ff)
		hold_acknowledge_pin_in <= 1'b1;
		settle();
		`CHK("arb slave", 1'b1, arb_granted_ff)
		cyc(n0);
		cfg(RST | 32'h5);
		cyc(n1);
		cfg(RST | 32'hF);
		cyc(n2);
		`CHK("waits f0", 15, n0 - n2)
		`CHK("waits f5", 10, n1 - n2)
		cfg(RST | 32'h2F);
		ready_lag = 4'h5;
		cyc(n0);
		ready_lag = 4'hC;
		cyc(n1);
		`CHK("ready stretch", 7, n1 - n0)
		wr(8'h40, RST & 32'hFF9F_FFFF);
		settle();
		`CHK("sm held", 1'b1, sm_in_reset_ff)
		`CHK("bc held", 1'b1, bc_in_reset_ff)
		wr(8'h4C, 32'h0);
		#1;
		`CHK("fetch refused", 2'h0, tx_fetch_ff)
		wr(8'h40, RST);
		settle();
		`CHK("sm run", 1'b0, sm_in_reset_ff)
		`CHK("bc run", 1'b0, bc_in_reset_ff)
		tx_hold <= 2'h1;
		wr(8'h4C, 32'h0);
		#1;
		`CHK("fetch held", 2'h2, tx_fetch_ff)
		tx_hold <= 2'h0;
		wr(8'h4C, 32'h0);
		#1;
		`CHK("fetch both", 2'h3, tx_fetch_ff)
		for (int m = 0; m < 4; m++) begin
			cfg(RST | (32'(m) << 27));
			`CHK("mode", {m[0], m[1]}, chan_dma_mode_ff)
		end
		wr(8'hF4, 32'h1);
		cfg(RST | 32'h0100_0000);
		dma_ack_int <= 4'h1;
		settle();
		`CHK("comb a", 1'b1, dma_ack_combined_a_ff)
		dma_ack_int <= 4'h8;
		settle();
		`CHK("comb b", 1'b1, dma_ack_combined_b_ff)
		`CHK("comb a off", 1'b0, dma_ack_combined_a_ff)
		// Phase-one pin follows the toggling bus clock; the other stays low
		d[0] = bus_clock_phase_one_out_ff;
		`CHK("phase off", 1'b0, extra_clock_phase_one_out_ff)
		@(posedge core_clk);
		#1;
		`CHK("phase one", 1'b1, d[0] ^ bus_clock_phase_one_out_ff)
		`CHK("phase off 2", 1'b0, extra_clock_phase_one_out_ff)
		cfg(RST);
		dma_ack_int <= 4'h2;
		settle();
		`CHK("rx a", 1'b1, dma_ack_rx_a_ff)
		cfg(RST | 32'h0400_0000);
		`CHK("shared ack", 2'h2, {dma_ack_combined_a_ff, dma_ack_rx_a_ff})
		`CHK("shared rx", 1'b0, req_a_tx_ff)
		cfg(RST | 32'h0600_0000);
		`CHK("shared tx", 1'b1, req_a_tx_ff)
		// Eight-period hold-off: about sixteen core cycles after the drop
		cfg(RST | 32'h0014_0000);
		dma_request_a <= 1'b1;
		settle();
		dma_request_a <= 1'b0;
		repeat (5) settle();
		`CHK("val hold", 1'b1, req_a_valid_ff)
		repeat (5) settle();
		`CHK("val end", 1'b0, req_a_valid_ff)
		irq_is_upper_status <= 2'h2;
		cfg(RST | 32'h4000_0000);
		`CHK("disregard a", 2'h1, irq_to_queue_ff)
		cfg(RST | 32'h8000_0000);
		`CHK("pass upper", 2'h2, irq_to_queue_ff)
		cfg(RST | 32'h1000);
		irq_low <= 1'b1;
		irq_on  <= 2'h1;
		settle();
		`CHK("irq a low", 1'b1, irq_a_ff)
		`CHK("irq b shared", 1'b1, irq_b_ff)
		cfg(RST | 32'h0400);
		irq_low <= 1'b0;
		irq_on  <= 2'h2;
		settle();
		`CHK("irq a sep", 1'b0, irq_a_ff)
		`CHK("irq b sep", 1'b1, irq_b_ff)
		report_and_stop();
	end
endmodule : tb_local_bus_peripheral_config
`default_nettype wire
